// ---- inc/pkt_bus_defs.svh ----
// constants of the packet system bus
`ifndef PKT_BUS_DEFS_SVH
`define PKT_BUS_DEFS_SVH
`define DATA_W    8
`define ADDR_W    5
`define PHY_PORTS 4
`define PORT_BASE 5'h00
`define IDX_W     2
`endif

// ---- inc/pkt_bus_if.sv ----
// wires of the packet system bus between link end and phy end
`timescale 1ns/100ps
`include "pkt_bus_defs.svh"
interface pkt_bus_if;
  // transmit, driven by the link end
  pkt_bus_pkg::byte_t      tx_data;
  logic                    tx_write_enable_n;
  pkt_bus_pkg::port_addr_t tx_port_addr;
  logic                    tx_packet_start;
  logic                    tx_packet_end;
  logic                    tx_addr_cycle;
  // transmit status, driven by the phy end
  logic [`PHY_PORTS-1:0]   tx_direct_avail;
  logic                    tx_polled_avail;
  logic                    tx_spa_drv;
  logic                    tx_spa_oe_n;
  logic                    tx_selected_port_avail;
  // receive control, driven by the link end
  pkt_bus_pkg::port_addr_t rx_port_addr;
  logic                    rx_read_enable_n;
  // receive, driven by the phy end
  logic [`PHY_PORTS-1:0]   rx_direct_avail;
  logic                    rx_polled_avail;
  pkt_bus_pkg::byte_t      rx_data_drv;
  logic                    rx_valid_drv;
  logic                    rx_start_drv;
  logic                    rx_end_drv;
  logic                    rx_error_drv;
  logic                    rx_addr_cycle_drv;
  logic                    rx_bus_oe_n;
  // resolved wire levels, pulled low when released
  pkt_bus_pkg::byte_t      rx_data;
  logic                    rx_valid;
  logic                    rx_packet_start;
  logic                    rx_packet_end;
  logic                    rx_packet_error;
  logic                    rx_addr_cycle;

  assign tx_selected_port_avail = tx_spa_drv & ~tx_spa_oe_n;
  assign rx_data         = rx_bus_oe_n ? 8'h00 : rx_data_drv;
  assign rx_valid        = rx_valid_drv & ~rx_bus_oe_n;
  assign rx_packet_start = rx_start_drv & ~rx_bus_oe_n;
  assign rx_packet_end   = rx_end_drv & ~rx_bus_oe_n;
  assign rx_packet_error = rx_error_drv & ~rx_bus_oe_n;
  assign rx_addr_cycle   = rx_addr_cycle_drv & ~rx_bus_oe_n;

  modport phy (
    input  tx_data, tx_write_enable_n, tx_port_addr, tx_packet_start,
    input  tx_packet_end, tx_addr_cycle, rx_port_addr, rx_read_enable_n,
    output tx_direct_avail, tx_polled_avail, tx_spa_drv, tx_spa_oe_n,
    output rx_direct_avail, rx_polled_avail, rx_data_drv, rx_valid_drv,
    output rx_start_drv, rx_end_drv, rx_error_drv, rx_addr_cycle_drv,
    output rx_bus_oe_n
  );
  modport link (
    output tx_data, tx_write_enable_n, tx_port_addr, tx_packet_start,
    output tx_packet_end, tx_addr_cycle, rx_port_addr, rx_read_enable_n,
    input  tx_direct_avail, tx_polled_avail, tx_selected_port_avail,
    input  rx_direct_avail, rx_polled_avail, rx_data, rx_valid,
    input  rx_packet_start, rx_packet_end, rx_packet_error, rx_addr_cycle
  );
endinterface : pkt_bus_if

// ---- inc/pkt_bus_pkg.sv ----
// types of the packet system bus
`include "pkt_bus_defs.svh"
package pkt_bus_pkg;
  typedef enum logic [1:0] {
    MODE_L2_DIRECT,
    MODE_L2_POLLED,
    MODE_L3
  } bus_mode_t;
  typedef enum {RX3_IDLE, RX3_ADDR, RX3_DATA} rx3_state_t;
  typedef enum {CT_IDLE, CT_POLL, CT_CHECK, CT_DATA} ctl_tx_state_t;
  typedef logic [`ADDR_W-1:0] port_addr_t;
  typedef logic [`DATA_W-1:0] byte_t;
endpackage : pkt_bus_pkg

// ---- rtl/pkt_link_end.sv ----
// link end of the packet system bus
`timescale 1ns/100ps
`include "pkt_bus_defs.svh"
module pkt_link_end (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // configuration
  input  wire pkt_bus_pkg::bus_mode_t mode,
  // bus
  pkt_bus_if.link                     bus,
  // transmit requests
  input  wire logic                   tx_start,
  input  wire pkt_bus_pkg::port_addr_t tx_port,
  input  wire logic [7:0]             tx_len,
  output logic                        tx_busy_q,
  // receive requests
  input  wire logic                   rx_start,
  input  wire pkt_bus_pkg::port_addr_t rx_port,
  input  wire logic                   rx_accept,
  output logic                        rx_busy_q,
  // received bytes
  output logic                        got_valid_q,
  output pkt_bus_pkg::byte_t          got_data_q,
  output logic                        got_start_q,
  output logic                        got_end_q,
  output logic                        got_error_q,
  output pkt_bus_pkg::port_addr_t     got_port_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // transmit
  pkt_bus_pkg::ctl_tx_state_t tx_q;
  logic [7:0]                 len_q;
  logic [7:0]                 cnt_q;
  logic                       ok;
  logic                       last;

  assign ok   = (mode != pkt_bus_pkg::MODE_L2_DIRECT) ||
                bus.tx_direct_avail[bus.tx_port_addr[`IDX_W-1:0]];
  assign last = (cnt_q + 8'h01 >= len_q);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q                  <= pkt_bus_pkg::CT_IDLE;
      len_q                 <= '0;
      cnt_q                 <= '0;
      tx_busy_q             <= 1'b0;
      bus.tx_data           <= '0;
      bus.tx_write_enable_n <= 1'b1;
      bus.tx_port_addr      <= '0;
      bus.tx_packet_start   <= 1'b0;
      bus.tx_packet_end     <= 1'b0;
      bus.tx_addr_cycle     <= 1'b0;
    end else begin
      bus.tx_write_enable_n <= 1'b1;
      bus.tx_packet_start   <= 1'b0;
      bus.tx_packet_end     <= 1'b0;
      bus.tx_addr_cycle     <= 1'b0;
      unique case (tx_q)
        pkt_bus_pkg::CT_IDLE: begin
          tx_busy_q <= tx_start;
          if (tx_start) begin
            len_q <= tx_len;
            cnt_q <= '0;
            if (mode == pkt_bus_pkg::MODE_L3) begin
              bus.tx_data       <= `DATA_W'(tx_port);
              bus.tx_addr_cycle <= 1'b1;
              tx_q              <= pkt_bus_pkg::CT_DATA;
            end else begin
              bus.tx_port_addr <= tx_port;
              tx_q <= (mode == pkt_bus_pkg::MODE_L2_POLLED) ?
                      pkt_bus_pkg::CT_POLL : pkt_bus_pkg::CT_DATA;
            end
          end
        end
        pkt_bus_pkg::CT_POLL: begin
          tx_q <= pkt_bus_pkg::CT_CHECK;
        end
        pkt_bus_pkg::CT_CHECK: begin
          if (bus.tx_polled_avail) begin
            tx_q <= pkt_bus_pkg::CT_DATA;
          end
        end
        pkt_bus_pkg::CT_DATA: begin
          if (ok) begin
            bus.tx_write_enable_n <= 1'b0;
            bus.tx_data           <= cnt_q;
            bus.tx_packet_start   <= (cnt_q == 8'h00);
            bus.tx_packet_end     <= last;
            cnt_q                 <= cnt_q + 8'h01;
            if (last) begin
              tx_q <= pkt_bus_pkg::CT_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive control
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_busy_q            <= 1'b0;
      bus.rx_port_addr     <= '0;
      bus.rx_read_enable_n <= 1'b1;
    end else if (mode == pkt_bus_pkg::MODE_L3) begin
      rx_busy_q            <= 1'b0;
      bus.rx_read_enable_n <= !rx_accept;
    end else if (rx_start && (!rx_busy_q || mode == pkt_bus_pkg::MODE_L2_DIRECT)) begin
      rx_busy_q            <= 1'b1;
      bus.rx_port_addr     <= rx_port;
      bus.rx_read_enable_n <= 1'b0;
    end else if (bus.rx_valid && bus.rx_packet_end) begin
      rx_busy_q            <= 1'b0;
      bus.rx_read_enable_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive capture
  pkt_bus_pkg::port_addr_t prev_addr_q;
  pkt_bus_pkg::port_addr_t cap_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prev_addr_q <= '0;
      cap_q       <= '0;
      got_valid_q <= 1'b0;
      got_data_q  <= '0;
      got_start_q <= 1'b0;
      got_end_q   <= 1'b0;
      got_error_q <= 1'b0;
      got_port_q  <= '0;
    end else begin
      prev_addr_q <= bus.rx_port_addr;
      if (bus.rx_addr_cycle) begin
        cap_q <= bus.rx_data[`ADDR_W-1:0];
      end
      got_valid_q <= bus.rx_valid;
      got_data_q  <= bus.rx_data;
      got_start_q <= bus.rx_valid && bus.rx_packet_start;
      got_end_q   <= bus.rx_valid && bus.rx_packet_end;
      got_error_q <= bus.rx_valid && bus.rx_packet_error;
      got_port_q  <= (mode == pkt_bus_pkg::MODE_L3) ? cap_q : prev_addr_q;
    end
  end

endmodule : pkt_link_end

// ---- rtl/pkt_phy_end.sv ----
// phy end of the packet system bus, four ports
`timescale 1ns/100ps
`include "pkt_bus_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - direct transmit flag drops when port full
// - link may switch port mid-stream, direct mode
// - direct transmit flag returns when space
// - direct receive flag high while data waiting
// - address swap moves sending port next cycle
// - start marker only on first byte
// - enable removed: valid drops and bus released in the same cycle
// - resumed packet continues without start marker
// - end marker on last byte, then stop
// - receive flag drops when nothing waits
// - polled transmit answer cycle after poll
// - polled: select first, then enable with start
// - selected-port flag driven, released on next start for a port not on this phy
// - link ends with end marker, enable off
// - polled receive answer when data waits
// - port begins cycle after enable and address
// - polled receive release cycle after enable off
// - same timing reselecting the same port
// - level-3 transmit address cycle, enable off
// - level-3 packet starts cycle after address
// - level-3 selected-port flag follows space
// - level-3 receive: phy sends address cycle
// - level-3 link enables before address cycle
////////////////////////////////////////////////////////////////////////////////
module pkt_phy_end (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // configuration
  input  wire pkt_bus_pkg::bus_mode_t        mode,
  // bus
  pkt_bus_if.phy                             bus,
  // transmit sink
  input  wire logic [`PHY_PORTS-1:0]         tx_space,
  output logic                               tx_out_valid_q,
  output logic [`IDX_W-1:0]                  tx_out_port_q,
  output pkt_bus_pkg::byte_t                 tx_out_data_q,
  output logic                               tx_out_start_q,
  output logic                               tx_out_end_q,
  // receive source
  input  wire logic [`PHY_PORTS-1:0]         rx_block,
  input  wire logic [`PHY_PORTS-1:0]         rx_src_valid,
  input  wire logic [`PHY_PORTS-1:0][`DATA_W-1:0] rx_src_data,
  input  wire logic [`PHY_PORTS-1:0]         rx_src_start,
  input  wire logic [`PHY_PORTS-1:0]         rx_src_end,
  input  wire logic [`PHY_PORTS-1:0]         rx_src_error,
  output logic [`PHY_PORTS-1:0]              rx_src_take
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  logic                    l2;
  logic                    l3;
  logic                    polled;
  pkt_bus_pkg::port_addr_t toff;
  pkt_bus_pkg::port_addr_t roff;
  pkt_bus_pkg::port_addr_t ioff;
  logic                    tmine;
  logic                    rmine;
  logic                    ren;

  assign l3     = (mode == pkt_bus_pkg::MODE_L3);
  assign l2     = !l3;
  assign polled = (mode == pkt_bus_pkg::MODE_L2_POLLED);
  assign toff   = bus.tx_port_addr - `PORT_BASE;
  assign roff   = bus.rx_port_addr - `PORT_BASE;
  assign ioff   = bus.tx_data[`ADDR_W-1:0] - `PORT_BASE;
  assign tmine  = (toff < `ADDR_W'(`PHY_PORTS));
  assign rmine  = (roff < `ADDR_W'(`PHY_PORTS));
  assign ren    = !bus.rx_read_enable_n;

  ////////////////////////////////////////////////////////////////////////////////
  // availability flags
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus.tx_direct_avail <= '0;
      bus.rx_direct_avail <= '0;
      bus.tx_polled_avail <= 1'b0;
      bus.rx_polled_avail <= 1'b0;
    end else begin
      bus.tx_direct_avail <= tx_space;
      bus.rx_direct_avail <= rx_block;
      bus.tx_polled_avail <= tmine && tx_space[toff[`IDX_W-1:0]];
      bus.rx_polled_avail <= rmine && rx_block[roff[`IDX_W-1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit port selection
  logic              tsel_ok_q;
  logic [`IDX_W-1:0] tsel_q;
  logic              thit;
  logic [`IDX_W-1:0] tport;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tsel_ok_q <= 1'b0;
      tsel_q    <= '0;
    end else if (l3 && bus.tx_addr_cycle && bus.tx_write_enable_n) begin
      tsel_ok_q <= (ioff < `ADDR_W'(`PHY_PORTS));
      tsel_q    <= ioff[`IDX_W-1:0];
    end
  end

  always_comb begin
    thit  = 1'b0;
    tport = toff[`IDX_W-1:0];
    if (!bus.tx_write_enable_n) begin
      if (l3) begin
        thit  = tsel_ok_q;
        tport = tsel_q;
      end else begin
        thit  = tmine;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit sink
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_out_valid_q <= 1'b0;
      tx_out_port_q  <= '0;
      tx_out_data_q  <= '0;
      tx_out_start_q <= 1'b0;
      tx_out_end_q   <= 1'b0;
    end else begin
      tx_out_valid_q <= thit;
      tx_out_port_q  <= tport;
      tx_out_data_q  <= bus.tx_data;
      tx_out_start_q <= thit && bus.tx_packet_start;
      tx_out_end_q   <= thit && bus.tx_packet_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // selected-port availability
  logic              spa_on_q;
  logic              spa_on_d;
  logic [`IDX_W-1:0] spa_port_q;
  logic [`IDX_W-1:0] spa_port_d;
  logic              tstart;

  assign tstart = !bus.tx_write_enable_n && bus.tx_packet_start;

  always_comb begin
    spa_on_d   = spa_on_q;
    spa_port_d = spa_port_q;
    if (tstart) begin
      spa_on_d   = thit;
      spa_port_d = tport;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      spa_on_q        <= 1'b0;
      spa_port_q      <= '0;
      bus.tx_spa_drv  <= 1'b0;
      bus.tx_spa_oe_n <= 1'b1;
    end else begin
      spa_on_q        <= spa_on_d;
      spa_port_q      <= spa_port_d;
      bus.tx_spa_drv  <= spa_on_d && tx_space[spa_port_d];
      bus.tx_spa_oe_n <= !(l3 || (polled && spa_on_d));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // level-3 receive port choice
  pkt_bus_pkg::rx3_state_t rx3_q;
  logic [`IDX_W-1:0]       cur_q;
  logic [`IDX_W-1:0]       pick;
  logic                    pick_ok;
  logic                    go3;
  logic                    end_taken;

  always_comb begin
    pick    = '0;
    pick_ok = 1'b0;
    for (int i = `PHY_PORTS - 1; i >= 0; i--) begin
      if (rx_block[i]) begin
        pick    = `IDX_W'(i);
        pick_ok = 1'b1;
      end
    end
  end

  assign go3 = l3 && ren && pick_ok && (rx3_q == pkt_bus_pkg::RX3_IDLE);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx3_q <= pkt_bus_pkg::RX3_IDLE;
      cur_q <= '0;
    end else if (!l3) begin
      rx3_q <= pkt_bus_pkg::RX3_IDLE;
    end else begin
      unique case (rx3_q)
        pkt_bus_pkg::RX3_IDLE: begin
          if (go3) begin
            rx3_q <= pkt_bus_pkg::RX3_ADDR;
            cur_q <= pick;
          end
        end
        pkt_bus_pkg::RX3_ADDR,
        pkt_bus_pkg::RX3_DATA: begin
          if (end_taken) begin
            rx3_q <= pkt_bus_pkg::RX3_IDLE;
          end else begin
            rx3_q <= pkt_bus_pkg::RX3_DATA;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive byte taking
  pkt_bus_pkg::port_addr_t raddr_q;
  logic                    done_q;
  logic [`IDX_W-1:0]       ridx;

  assign ridx = l3 ? cur_q : roff[`IDX_W-1:0];

  always_comb begin
    rx_src_take = '0;
    if (l2 && ren && rmine && !done_q) begin
      rx_src_take[ridx] = rx_src_valid[ridx];
    end else if (l3 && ren && rx3_q != pkt_bus_pkg::RX3_IDLE) begin
      rx_src_take[ridx] = rx_src_valid[ridx];
    end
  end

  assign end_taken = |(rx_src_take & rx_src_end);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      raddr_q <= '0;
      done_q  <= 1'b0;
    end else begin
      raddr_q <= bus.rx_port_addr;
      done_q  <= l2 && ren &&
                 (end_taken || (done_q && bus.rx_port_addr == raddr_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive bus drive
  logic any_take;

  assign any_take = |rx_src_take;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus.rx_valid_drv      <= 1'b0;
      bus.rx_start_drv      <= 1'b0;
      bus.rx_end_drv        <= 1'b0;
      bus.rx_error_drv      <= 1'b0;
      bus.rx_addr_cycle_drv <= 1'b0;
      bus.rx_data_drv       <= '0;
      bus.rx_bus_oe_n       <= 1'b1;
    end else begin
      bus.rx_valid_drv      <= any_take;
      bus.rx_start_drv      <= any_take && rx_src_start[ridx];
      bus.rx_end_drv        <= any_take && rx_src_end[ridx];
      bus.rx_error_drv      <= any_take && rx_src_error[ridx];
      bus.rx_addr_cycle_drv <= go3;
      if (go3) begin
        bus.rx_data_drv <= `DATA_W'(`ADDR_W'(`PORT_BASE + `ADDR_W'(pick)));
      end else begin
        bus.rx_data_drv <= rx_src_data[ridx];
      end
      bus.rx_bus_oe_n       <= !(l3 || (ren && rmine));
    end
  end

endmodule : pkt_phy_end

// ---- verification/pkt_bus_asserts.sv ----
// concurrent checks on the packet bus between link end and phy end
`timescale 1ns/100ps
`include "pkt_bus_defs.svh"
module pkt_bus_asserts (
  // clock and reset
  input logic                    clock,
  input logic                    sys_rst,
  // configuration and sources
  input pkt_bus_pkg::bus_mode_t  mode,
  input logic [`PHY_PORTS-1:0]   tx_space,
  // transmit
  input logic                    tx_write_enable_n,
  input pkt_bus_pkg::port_addr_t tx_port_addr,
  input logic                    tx_packet_start,
  input logic [`PHY_PORTS-1:0]   tx_direct_avail,
  input logic                    tx_polled_avail,
  input logic                    tx_spa_oe_n,
  // receive
  input pkt_bus_pkg::port_addr_t rx_port_addr,
  input logic                    rx_read_enable_n,
  input logic                    rx_bus_oe_n,
  input logic                    rx_valid,
  input logic                    rx_packet_start,
  input logic                    rx_packet_end,
  input logic                    rx_addr_cycle
);
  logic l2;
  logic tx_mine;
  logic rx_mine;
  logic poll_cause;
  assign l2 = mode != pkt_bus_pkg::MODE_L3;
  assign tx_mine = (tx_port_addr - `PORT_BASE) < `PHY_PORTS;
  assign rx_mine = (rx_port_addr - `PORT_BASE) < `PHY_PORTS;
  assign poll_cause = tx_mine && tx_space[tx_port_addr[`IDX_W-1:0]];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_rx_start_once: assert property (
    rx_valid && rx_packet_start && !rx_packet_end |=> !rx_packet_start)
    else $error("start marker repeated");
  a_rx_end_stop: assert property (
    rx_valid && rx_packet_end |=> !rx_valid && !rx_packet_end)
    else $error("valid or end held after last byte");
  a_rx_release: assert property (
    l2 && $rose(rx_read_enable_n) |=> !rx_valid && rx_bus_oe_n)
    else $error("receive bus not released after enable removed");
  a_rx_idle_float: assert property (
    l2 && (rx_read_enable_n || !rx_mine) |=> rx_bus_oe_n)
    else $error("receive bus driven while not addressed");
  a_rx_own_drive: assert property (
    l2 && !rx_read_enable_n && rx_mine |=> !rx_bus_oe_n)
    else $error("receive bus not driven when addressed");
  a_spa_drive: assert property (
    mode == pkt_bus_pkg::MODE_L2_POLLED && !tx_write_enable_n && tx_packet_start
    && tx_mine |=> !tx_spa_oe_n)
    else $error("selected port flag not driven after start");
  a_tx_direct_follow: assert property (
    mode == pkt_bus_pkg::MODE_L2_DIRECT |=> tx_direct_avail == $past(tx_space))
    else $error("direct transmit flags do not follow space");
  a_tx_poll_answer: assert property (
    mode == pkt_bus_pkg::MODE_L2_POLLED |=> tx_polled_avail == $past(poll_cause))
    else $error("polled transmit answer wrong");
  a_rx_addr_strobe: assert property (
    rx_addr_cycle |-> !rx_valid ##1 !rx_addr_cycle)
    else $error("receive address strobe malformed");
  c_rx_end: cover property (rx_valid && rx_packet_end);
  c_spa_driven: cover property (!tx_spa_oe_n);
  c_rx_addr: cover property (rx_addr_cycle);
endmodule : pkt_bus_asserts

// ---- verification/test_packet_bus_phy_side_l2_l3.sv ----
// bench for the packet bus, both ends facing each other
`timescale 1ns/100ps
`include "pkt_bus_defs.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module test_packet_bus_phy_side_l2_l3;
  localparam int RXLEN = 5;
  logic                    clock = 0, sys_rst = 1, tx_start = 0, rx_start = 0, rx_accept = 0;
  pkt_bus_pkg::bus_mode_t  mode = pkt_bus_pkg::MODE_L2_DIRECT;
  logic [3:0]              tx_space = 4'hF, src_en = 4'h0;
  logic [3:0]              rx_src_take, src_start, src_end, src_err;
  logic [3:0][7:0]         src_data;
  logic [5:0]              cnt [4];
  logic [5:0]              ei [4];
  pkt_bus_pkg::port_addr_t tx_port = 5'h00, rx_port = 5'h00, got_port_q;
  logic [7:0]              tx_len = 8'h00;
  logic                    tx_out_valid_q, tx_out_start_q, tx_out_end_q;
  logic                    got_valid_q, got_start_q, got_end_q, got_error_q;
  logic [1:0]              tx_out_port_q;
  pkt_bus_pkg::byte_t      tx_out_data_q, got_data_q;
  int                      err_count = 0, checked = 0, lat = 0, l0;
  ////////////////////////////////////////////////////////////////////////////////
  // per-port packet sources, show-ahead
  always #10 clock = ~clock;
  always_comb for (int p = 0; p < 4; p++) begin
    src_data[p] = {p[1:0], cnt[p]};
    src_start[p] = cnt[p] == 6'h00;
    src_end[p] = cnt[p] == RXLEN - 1;
    src_err[p] = src_end[p] && p == 3;
  end
  always @(posedge clock or posedge sys_rst)
    for (int p = 0; p < 4; p++)
      if (sys_rst) cnt[p] <= 6'h00;
      else if (rx_src_take[p]) cnt[p] <= src_end[p] ? 6'h00 : cnt[p] + 6'h01;
  ////////////////////////////////////////////////////////////////////////////////
  pkt_bus_if bus ();
  pkt_phy_end pkt_phy_end_inst (.clock(clock), .sys_rst(sys_rst), .mode(mode), .bus(bus),
    .tx_space(tx_space), .tx_out_valid_q(tx_out_valid_q), .tx_out_port_q(tx_out_port_q),
    .tx_out_data_q(tx_out_data_q), .tx_out_start_q(tx_out_start_q),
    .tx_out_end_q(tx_out_end_q), .rx_block(src_en), .rx_src_valid(src_en),
    .rx_src_data(src_data), .rx_src_start(src_start), .rx_src_end(src_end),
    .rx_src_error(src_err), .rx_src_take(rx_src_take));
  pkt_link_end pkt_link_end_inst (.clock(clock), .sys_rst(sys_rst), .mode(mode), .bus(bus),
    .tx_start(tx_start), .tx_port(tx_port), .tx_len(tx_len), .tx_busy_q(),
    .rx_start(rx_start), .rx_port(rx_port), .rx_accept(rx_accept), .rx_busy_q(),
    .got_valid_q(got_valid_q), .got_data_q(got_data_q), .got_start_q(got_start_q),
    .got_end_q(got_end_q), .got_error_q(got_error_q), .got_port_q(got_port_q));
  pkt_bus_asserts pkt_bus_asserts_inst (.clock(clock), .sys_rst(sys_rst), .mode(mode),
    .tx_space(tx_space), .tx_write_enable_n(bus.tx_write_enable_n),
    .tx_port_addr(bus.tx_port_addr), .tx_packet_start(bus.tx_packet_start),
    .tx_direct_avail(bus.tx_direct_avail), .tx_polled_avail(bus.tx_polled_avail),
    .tx_spa_oe_n(bus.tx_spa_oe_n), .rx_port_addr(bus.rx_port_addr),
    .rx_read_enable_n(bus.rx_read_enable_n), .rx_bus_oe_n(bus.rx_bus_oe_n),
    .rx_valid(bus.rx_valid), .rx_packet_start(bus.rx_packet_start),
    .rx_packet_end(bus.rx_packet_end), .rx_addr_cycle(bus.rx_addr_cycle));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic init(input pkt_bus_pkg::bus_mode_t m);
    mode = m;
    sys_rst = 1;
    ei = '{default: 6'h00};
    repeat (6) @(posedge clock);
    #1 sys_rst = 0;
  endtask : init

  task automatic txp(input logic [4:0] port, input int len, input int xn, input bit stall);
    int n;
    n = 0;
    tx_port = port;
    tx_len = len[7:0];
    tx_start = 1;
    for (int c = 0; c < 40; c++) begin
      @(posedge clock);
      #1;
      if (c == 0) tx_start = 0;
      tx_space = (stall && c > 3 && c < 10) ? 4'hD : 4'hF;
      if (tx_out_valid_q === 1'b1) begin
        `CHK("tx data", n[7:0], tx_out_data_q)
        `CHK("tx start", n == 0, tx_out_start_q)
        `CHK("tx end", n == len - 1, tx_out_end_q)
        `CHK("tx port", port[1:0], tx_out_port_q)
        if (n == 1 && mode != pkt_bus_pkg::MODE_L2_DIRECT)
          `CHK("tx spa", 1'b1, bus.tx_selected_port_avail)
        n++;
      end
    end
    `CHK("tx count", xn, n)
  endtask : txp

  task automatic rxc(input logic [1:0] port, input int n, input int xs);
    int k, s;
    logic [1:0] p;
    k = 0;
    s = 0;
    for (int c = 0; c < 60 && k < n; c++) begin
      @(posedge clock);
      #1;
      if (c == 0) rx_start = 0;
      if (got_valid_q === 1'b1) begin
        p = got_data_q[7:6];
        if (k == 0 && p == port) lat = c;
        `CHK("rx data", {p, ei[p]}, got_data_q)
        `CHK("rx start", ei[p] == 0, got_start_q)
        `CHK("rx end", ei[p] == RXLEN - 1, got_end_q)
        `CHK("rx error", p == 3 && ei[p] == RXLEN - 1, got_error_q)
        `CHK("rx port", `PORT_BASE + {3'h0, p}, got_port_q)
        ei[p] = ei[p] == RXLEN - 1 ? 6'h00 : ei[p] + 6'h01;
        if (p == port) k++;
        else s++;
      end
    end
    `CHK("rx count", n, k)
    if (xs >= 0) `CHK("rx stray", xs, s)
  endtask : rxc

  task automatic rxp(input logic [4:0] port, input int n, input int xs, input bit sw);
    if (!sw) begin
      repeat (3) @(posedge clock);
      #1;
    end
    rx_port = port;
    rx_start = 1;
    rxc(port[1:0], n, xs);
  endtask : rxp
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    err_count++;
    summarize();
  end

  initial begin
    init(pkt_bus_pkg::MODE_L2_DIRECT);
    txp(5'h01, 6, 6, 1'b1);
    txp(5'h09, 3, 0, 1'b0);
    src_en = 4'h5;
    repeat (2) @(posedge clock);
    #1 `CHK("rx flags", 4'h5, bus.rx_direct_avail)
    rxp(5'h00, 2, 0, 1'b0);
    rxp(5'h02, RXLEN, 2, 1'b1);
    rxp(5'h00, 1, 0, 1'b0);
    src_en = 4'h0;
    repeat (2) @(posedge clock);
    #1 `CHK("rx flags", 4'h0, bus.rx_direct_avail)
    init(pkt_bus_pkg::MODE_L2_POLLED);
    txp(5'h02, 4, 4, 1'b0);
    txp(5'h00, 1, 1, 1'b0);
    src_en = 4'h8;
    rxp(5'h03, RXLEN, 0, 1'b0);
    l0 = lat;
    rxp(5'h03, RXLEN, 0, 1'b0);
    `CHK("rx latency", l0, lat)
    init(pkt_bus_pkg::MODE_L3);
    txp(5'h03, 5, 5, 1'b0);
    src_en = 4'h4;
    rx_accept = 1;
    rxc(2'h2, RXLEN, 0);
    src_en = 4'h6;
    rxc(2'h1, RXLEN, RXLEN);
    summarize();
  end
endmodule : test_packet_bus_phy_side_l2_l3
